// >>> inc/stepper_port_pkg.sv
// shared constants and carrier types for the stepper axis host port
package stepper_port_pkg;

   // ==========================================================
   // byte lanes on the two low address lines
   localparam logic [1:0] LANE_CMD = 2'h0;
   localparam logic [1:0] LANE_LOW = 2'h1;
   localparam logic [1:0] LANE_MID = 2'h2;
   localparam logic [1:0] LANE_UP = 2'h3;

   // ==========================================================
   // command groups in the two top bits of a command byte
   localparam int GRP_MSB = 7;
   localparam int GRP_LSB = 6;
   localparam logic [1:0] GRP_START = 2'h0;
   localparam logic [1:0] GRP_CONTROL = 2'h1;
   localparam logic [1:0] GRP_REGSEL = 2'h2;
   localparam logic [1:0] GRP_OUTMODE = 2'h3;

   // command reset values
   localparam logic [7:0] START_CMD_RESET = 8'h00;
   localparam logic [7:0] CONTROL_CMD_RESET = 8'h40;
   localparam logic [7:0] REGSEL_CMD_RESET = 8'h80;
   localparam logic [7:0] OUTMODE_CMD_RESET = 8'hC0;
   localparam logic [23:0] REG_RESET = 24'h000000;

   // ==========================================================
   // field positions
   localparam int REGSEL_MSB = 2;
   localparam int MONITOR_EXT_BIT = 5;
   localparam int START_CTRL_BIT = 1;

   // register numbers
   localparam logic [2:0] REG_REMAINING_PULSE_COUNTER = 3'h0;
   localparam logic [2:0] REG_START_SPEED_SETTING = 3'h1;
   localparam logic [2:0] REG_RUN_SPEED_SETTING = 3'h2;
   localparam logic [2:0] REG_RAMP_RATE_SETTING = 3'h3;
   localparam logic [2:0] REG_SPEED_SCALE_SETTING = 3'h4;
   localparam logic [2:0] REG_RAMP_DOWN_POINT = 3'h5;
   localparam logic [2:0] REG_AUX_REGISTER_SIX = 3'h6;
   localparam logic [2:0] REG_STATUS_VIEW_SLOT = 3'h7;

   // valid start speed range
   localparam logic [23:0] START_SPEED_MIN = 24'h000001;
   localparam logic [23:0] START_SPEED_MAX = 24'h001FFF;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0] start_cmd;
      logic [7:0] control_cmd;
      logic [7:0] regsel_cmd;
      logic [7:0] outmode_cmd;
      logic [6:1][23:0] regs;
   } axis_cfg_s;

   typedef struct packed {
      logic [23:0] remaining;
      logic [15:0] speed;
      logic running;
      logic [7:0] operation_status_byte;
      logic [7:0] output_status_byte;
      logic [23:0] status_view_slot;
   } axis_live_s;

   typedef struct packed {
      logic end_limit_input_pos;
      logic end_limit_input_neg;
      logic slow_down_input_pos;
      logic slow_down_input_neg;
      logic origin_input;
      logic external_start_input;
      logic external_stop_input;
      logic phase_zero;
   } pin_in_s;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] lane;
      logic [1:0] axis;
      logic [7:0] data;
   } bus_pins_s;

endpackage

// >>> core/sync_2ff.sv
// two-flop synchroniser for a vector of independent levels
module sync_2ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // ==========================================================
   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// >>> core/monitor_view.sv
// read-side byte selection for one axis
module monitor_view #(
   parameter logic [7:0] TYPE_IDENT = 8'h5A
) (
   input wire stepper_port_pkg::axis_cfg_s cfg,
   input wire stepper_port_pkg::axis_live_s live,
   input wire stepper_port_pkg::pin_in_s pins,
   input wire logic [23:0] snap,
   input wire logic [1:0] lane,
   output logic [7:0] byte_out
);

   logic [2:0] sel;
   logic ext;
   logic [7:0] start_view;
   logic [7:0] input_status_byte;
   logic [7:0] cmd_view;

   always_comb begin
      sel = cfg.regsel_cmd[stepper_port_pkg::REGSEL_MSB:0];
      ext = cfg.outmode_cmd[stepper_port_pkg::MONITOR_EXT_BIT];
      input_status_byte = pins;
      // start control bit shows live motion, not what was written
      start_view = cfg.start_cmd;
      start_view[stepper_port_pkg::START_CTRL_BIT] = live.running; // (R17)
      case (sel)
         3'h1: cmd_view = start_view;
         3'h2: cmd_view = cfg.control_cmd;
         3'h3: cmd_view = cfg.regsel_cmd;
         3'h4: cmd_view = cfg.outmode_cmd;
         default: cmd_view = live.status_view_slot[7:0];
      endcase
      byte_out = 8'h00;
      if (lane == stepper_port_pkg::LANE_CMD) begin
         byte_out = live.operation_status_byte; // (R3)
      end else if (sel == stepper_port_pkg::REG_REMAINING_PULSE_COUNTER) begin
         // counter reads come from the snapshot, any byte order
         case (lane)
            stepper_port_pkg::LANE_LOW: byte_out = snap[7:0]; // (R9) (R12)
            stepper_port_pkg::LANE_MID: byte_out = snap[15:8];
            default: byte_out = snap[23:16];
         endcase
      end else if (!ext) begin
         if (lane == stepper_port_pkg::LANE_LOW) begin
            byte_out = input_status_byte; // (R12) (R16)
         end
      end else if (sel == stepper_port_pkg::REG_STATUS_VIEW_SLOT) begin
         case (lane)
            stepper_port_pkg::LANE_LOW: byte_out = input_status_byte; // (R14)
            stepper_port_pkg::LANE_MID: byte_out = live.output_status_byte; // (R16)
            default: byte_out = TYPE_IDENT;
         endcase
      end else if (sel == stepper_port_pkg::REG_AUX_REGISTER_SIX) begin
         // speed is live: a carry between bytes can tear the value
         case (lane)
            stepper_port_pkg::LANE_LOW: byte_out = cfg.regs[6][7:0]; // (R14)
            stepper_port_pkg::LANE_MID: byte_out = live.speed[7:0]; // (R18)
            default: byte_out = live.speed[15:8];
         endcase
      end else begin
         case (lane)
            stepper_port_pkg::LANE_LOW: byte_out = cfg.regs[sel][7:0]; // (R13) (R11)
            stepper_port_pkg::LANE_MID: byte_out = cfg.regs[sel][15:8];
            default: byte_out = cmd_view;
         endcase
      end
   end

endmodule

// >>> core/stepper_axis_host_port.sv
// 8-bit parallel host port of the stepper pulse sequencer
// Contract
// (R1) write lane 00 command, 01/10/11 low/mid/up
// (R2) command 10xxxxxx selects the target register
// (R3) read lane 00 status, 01/10/11 data bytes
// (R4) bus released while chip select high
// (R5) axis lines route access to one axis
// (R6) low byte write commits staged 24 bits
// (R7) host writes select, upper, middle, lower
// (R8) host idles two cycles after low byte
// (R9) selecting counter snapshots it for reads
// (R10) host waits 1.5 cycles before reading
// (R11) other values read live, host reads twice
// (R12) standard monitor: counter or input status
// (R13) extended: registers one-five plus command bytes
// (R14) extended: register six, speed, status bytes
// (R15) read byte latched at read start
// (R16) input, output and type status bytes
// (R17) start bit readback shows running state
// (R18) speed bytes live, may tear on carry
// (R19) immediate stop uses start speed if valid
// (R20) staging bytes persist until overwritten
// (R21) start-mode write triggers motion
// (R22) host sets one start/stop bit only
// (R23) data taken on write strobe rising edge
module stepper_axis_host_port #(
   parameter int AXES = 4,
   parameter logic [7:0] TYPE_IDENT = 8'h5A // arbitrary value
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] lane_addr,
   input wire logic [1:0] axis_addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire stepper_port_pkg::pin_in_s [AXES-1:0] axis_pins,
   input wire stepper_port_pkg::axis_live_s [AXES-1:0] axis_live,
   output stepper_port_pkg::axis_cfg_s [AXES-1:0] axis_cfg,
   output logic [AXES-1:0] start_trigger,
   output logic [AXES-1:0] stop_at_start_speed
);

   localparam logic [1:0] AXIS_MASK = 2'(AXES - 1);
   // strobes flush as idle highs, so no false write edge follows reset
   localparam stepper_port_pkg::bus_pins_s BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
      default: '0};

   // ==========================================================
   // state
   typedef struct packed {
      logic wr_q;
      logic rd_act;
      logic [7:0] lat_data;
      logic [1:0] lat_lane;
      logic [1:0] lat_axis;
      stepper_port_pkg::axis_cfg_s [AXES-1:0] cfg;
      logic [AXES-1:0][7:0] stage_up;
      logic [AXES-1:0][7:0] stage_mid;
      logic [AXES-1:0][23:0] snap;
      logic [AXES-1:0] start_trigger;
      logic [AXES-1:0] stop_fl;
      logic [7:0] data_out;
      logic data_oe;
   } state_s;

   state_s st;
   state_s next_st;
   state_s reset_st;

   stepper_port_pkg::bus_pins_s bus_raw;
   stepper_port_pkg::bus_pins_s bus;
   stepper_port_pkg::pin_in_s [AXES-1:0] pins;

   logic [1:0] rd_axis;
   logic [7:0] view_byte;
   logic read_req;
   logic write_edge;
   logic [1:0] w_axis;

   // ==========================================================
   // pin synchronisers
   always_comb begin
      bus_raw.cs_n = cs_n;
      bus_raw.rd_n = rd_n;
      bus_raw.wr_n = wr_n;
      bus_raw.lane = lane_addr;
      bus_raw.axis = axis_addr;
      bus_raw.data = data_in;
   end

   sync_2ff #(
      .WIDTH($bits(stepper_port_pkg::bus_pins_s)),
      .RESET_VAL(BUS_IDLE)
   ) u_bus_sync (
      .clk(clk),
      .resetn(resetn),
      .d(bus_raw),
      .q(bus)
   );

   // limit, slow-down, origin and start/stop pins arrive asynchronously
   sync_2ff #(
      .WIDTH(AXES * $bits(stepper_port_pkg::pin_in_s))
   ) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .d(axis_pins),
      .q(pins)
   );

   // ==========================================================
   // read view for the addressed axis
   assign rd_axis = bus.axis & AXIS_MASK; // (R5)

   monitor_view #(
      .TYPE_IDENT(TYPE_IDENT)
   ) u_view (
      .cfg(st.cfg[rd_axis]),
      .live(axis_live[rd_axis]),
      .pins(pins[rd_axis]),
      .snap(st.snap[rd_axis]),
      .lane(bus.lane),
      .byte_out(view_byte)
   );

   // ==========================================================
   // reset image
   always_comb begin
      reset_st = '0;
      for (int a = 0; a < AXES; a++) begin
         reset_st.cfg[a].start_cmd = stepper_port_pkg::START_CMD_RESET;
         reset_st.cfg[a].control_cmd = stepper_port_pkg::CONTROL_CMD_RESET;
         reset_st.cfg[a].regsel_cmd = stepper_port_pkg::REGSEL_CMD_RESET;
         reset_st.cfg[a].outmode_cmd = stepper_port_pkg::OUTMODE_CMD_RESET;
         for (int r = 1; r <= 6; r++) begin
            reset_st.cfg[a].regs[r] = stepper_port_pkg::REG_RESET;
         end
      end
      reset_st.wr_q = 1'b1;
   end

   // ==========================================================
   // strobe decode
   // simultaneous read and write strobes are illegal; both are ignored then
   assign read_req = !bus.cs_n && !bus.rd_n && bus.wr_n;
   // latched values belong to the cycle before the strobe rose
   assign write_edge = !st.wr_q && bus.wr_n; // (R23)
   assign w_axis = st.lat_axis & AXIS_MASK; // (R5)

   always_comb begin
      next_st = st;
      next_st.wr_q = bus.wr_n;
      next_st.start_trigger = '0;

      // hold bus contents while the write strobe is low and selected
      if (!bus.cs_n && !bus.wr_n && bus.rd_n) begin
         next_st.lat_data = bus.data;
         next_st.lat_lane = bus.lane;
         next_st.lat_axis = bus.axis;
      end

      // write side: only strobes seen with chip select low were latched
      if (write_edge && !bus.cs_n && bus.rd_n) begin
         case (st.lat_lane)
            stepper_port_pkg::LANE_CMD: begin // (R1)
               case (st.lat_data[stepper_port_pkg::GRP_MSB:stepper_port_pkg::GRP_LSB])
                  stepper_port_pkg::GRP_START: begin
                     next_st.cfg[w_axis].start_cmd = st.lat_data;
                     next_st.start_trigger[w_axis] = 1'b1; // (R21)
                  end
                  stepper_port_pkg::GRP_CONTROL: begin
                     next_st.cfg[w_axis].control_cmd = st.lat_data;
                  end
                  stepper_port_pkg::GRP_REGSEL: begin
                     next_st.cfg[w_axis].regsel_cmd = st.lat_data; // (R2)
                     // fresh snapshot on every selection of the counter, repeated or not
                     if (st.lat_data[stepper_port_pkg::REGSEL_MSB:0]
                         == stepper_port_pkg::REG_REMAINING_PULSE_COUNTER) begin
                        next_st.snap[w_axis] = axis_live[w_axis].remaining; // (R9)
                     end
                  end
                  default: begin
                     next_st.cfg[w_axis].outmode_cmd = st.lat_data;
                  end
               endcase
            end
            stepper_port_pkg::LANE_UP: begin
               next_st.stage_up[w_axis] = st.lat_data; // (R1) (R6)
            end
            stepper_port_pkg::LANE_MID: begin
               next_st.stage_mid[w_axis] = st.lat_data; // (R1) (R6)
            end
            default: begin
               // staged bytes are not cleared, so a short sequence reuses old ones
               case (st.cfg[w_axis].regsel_cmd[stepper_port_pkg::REGSEL_MSB:0])
                  stepper_port_pkg::REG_START_SPEED_SETTING,
                  stepper_port_pkg::REG_RUN_SPEED_SETTING,
                  stepper_port_pkg::REG_RAMP_RATE_SETTING,
                  stepper_port_pkg::REG_SPEED_SCALE_SETTING,
                  stepper_port_pkg::REG_RAMP_DOWN_POINT,
                  stepper_port_pkg::REG_AUX_REGISTER_SIX: begin
                     next_st.cfg[w_axis].regs[st.cfg[w_axis].regsel_cmd[2:0]] =
                        {st.stage_up[w_axis], st.stage_mid[w_axis], st.lat_data}; // (R6) (R20)
                  end
                  default: begin
                     // counter and status slot are not writable here
                     next_st.cfg[w_axis] = st.cfg[w_axis];
                  end
               endcase
            end
         endcase
      end

      // read side: byte frozen at the start of the read cycle
      if (read_req) begin
         if (!st.rd_act) begin
            next_st.data_out = view_byte; // (R15) (R11)
         end
         next_st.rd_act = 1'b1;
         next_st.data_oe = 1'b1; // (R3)
      end else begin
         next_st.rd_act = 1'b0;
         next_st.data_oe = 1'b0; // (R4)
      end

      // immediate stop: finish at start speed only if it is in range
      for (int a = 0; a < AXES; a++) begin
         next_st.stop_fl[a] =
            (next_st.cfg[a].regs[1] >= stepper_port_pkg::START_SPEED_MIN) &&
            (next_st.cfg[a].regs[1] <= stepper_port_pkg::START_SPEED_MAX); // (R19)
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= reset_st;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign data_out = st.data_out;
   assign data_oe = st.data_oe;
   assign axis_cfg = st.cfg;
   assign start_trigger = st.start_trigger;
   assign stop_at_start_speed = st.stop_fl;

endmodule

// >>> test/host_port_asserts.sv
// concurrent checks on the pins of the stepper host port
module host_port_asserts #(
   parameter int AXES = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] lane_addr,
   input wire logic [1:0] axis_addr,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire stepper_port_pkg::pin_in_s [AXES-1:0] axis_pins,
   input wire stepper_port_pkg::axis_live_s [AXES-1:0] axis_live,
   input wire stepper_port_pkg::axis_cfg_s [AXES-1:0] axis_cfg,
   input wire logic [AXES-1:0] start_trigger,
   input wire logic [AXES-1:0] stop_at_start_speed
);
   // ==========================================
   // cycles since the write strobe pin was low; saturates
   logic [3:0] since_wr;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         since_wr <= 4'hF;
      end else if (!wr_n) begin
         since_wr <= 4'h0;
      end else if (since_wr != 4'hF) begin
         since_wr <= since_wr + 4'h1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ==========================================
   // assertions
   oe_release_a: assert property (cs_n [*4] |-> !data_oe)
      else $error("data bus driven while deselected");
   read_drive_a: assert property ((!cs_n && !rd_n && wr_n) [*5] |-> data_oe)
      else $error("read cycle without bus drive");
   strobe_drop_a: assert property ($rose(rd_n) |-> ##[1:5] !data_oe)
      else $error("bus still driven after read release");
   read_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
      else $error("read byte changed within a read cycle");
   start_once_a: assert property (|start_trigger |=> start_trigger == '0)
      else $error("start trigger longer than one cycle");
   start_cause_a: assert property (|start_trigger |-> since_wr <= 4'h7)
      else $error("start trigger without a write");
   cfg_cause_a: assert property (!$stable(axis_cfg) |-> since_wr <= 4'h7)
      else $error("configuration changed without a write");
   group_bits_a: assert property (
      axis_cfg[0].regsel_cmd[7:6] == 2'h2 && axis_cfg[0].outmode_cmd[7:6] == 2'h3)
      else $error("command stored under the wrong group");
   // last axis: the bench moves its start speed across both range ends
   start_speed_a: assert property (
      $stable(axis_cfg[AXES-1].regs[1]) |-> stop_at_start_speed[AXES-1] ==
      (axis_cfg[AXES-1].regs[1] >= stepper_port_pkg::START_SPEED_MIN
      && axis_cfg[AXES-1].regs[1] <= stepper_port_pkg::START_SPEED_MAX))
      else $error("start speed validity flag wrong");

   cover property (|start_trigger);
   cover property ($rose(data_oe));
   cover property (stop_at_start_speed != '0);
endmodule

bind stepper_axis_host_port host_port_asserts #(.AXES(AXES)) chk (.clk, .resetn, .cs_n,
   .rd_n, .wr_n, .lane_addr, .axis_addr, .data_in, .data_out, .data_oe, .axis_pins,
   .axis_live, .axis_cfg, .start_trigger, .stop_at_start_speed);

// >>> test/host_cpu_model.sv
// host cpu model driving the parallel port strobes
module host_cpu_model (
   input wire logic clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [1:0] lane_addr,
   output logic [1:0] axis_addr,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      lane_addr = 2'h0;
      axis_addr = 2'h0;
      data_in = 8'h00;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ==========================================
   // strobes held several clocks: pins pass a two-flop synchroniser
   task automatic wr_byte(input logic [1:0] ax, input logic [1:0] ln, input logic [7:0] d);
      cs_n = 1'b0;
      axis_addr = ax;
      lane_addr = ln;
      data_in = d;
      wr_n = 1'b0;
      idle(4);
      wr_n = 1'b1;
      idle(1);
      cs_n = 1'b1;
      data_in = ~d;
      idle(5);
   endtask

   task automatic rd_byte(input logic [1:0] ax, input logic [1:0] ln, output logic [7:0] d);
      cs_n = 1'b0;
      axis_addr = ax;
      lane_addr = ln;
      rd_n = 1'b0;
      for (int i = 0; i < 12 && data_oe !== 1'b1; i++) begin
         idle(1);
      end
      idle(2);
      // an undriven bus yields no valid byte
      d = (data_oe === 1'b1) ? data_out : 8'hXX;
      rd_n = 1'b1;
      cs_n = 1'b1;
      idle(5);
   endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the stepper axis host port
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] TYPE_ID = 8'h3C; // arbitrary value
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cs_n, rd_n, wr_n, data_oe;
   logic [1:0] lane_addr, axis_addr;
   logic [7:0] data_in, data_out;
   stepper_port_pkg::pin_in_s [3:0] axis_pins = '0;
   stepper_port_pkg::axis_live_s [3:0] axis_live = '0;
   stepper_port_pkg::axis_cfg_s [3:0] axis_cfg;
   logic [3:0] start_trigger, stop_at_start_speed;
   logic [7:0] lane3_exp [1:5] = '{8'h04, 8'h55, 8'h83, 8'hE0, 8'hC3};
   int fail_count = 0;
   int checks_done = 0;
   int trig_count = 0;

   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (start_trigger[1] === 1'b1) begin
         trig_count++;
      end
   end

   host_cpu_model host (.clk, .cs_n, .rd_n, .wr_n, .lane_addr, .axis_addr, .data_in,
      .data_out, .data_oe);
   stepper_axis_host_port #(.AXES(4), .TYPE_IDENT(TYPE_ID)) uut (.clk, .resetn, .cs_n,
      .rd_n, .wr_n, .lane_addr, .axis_addr, .data_in, .data_out, .data_oe, .axis_pins,
      .axis_live, .axis_cfg, .start_trigger, .stop_at_start_speed);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // select, upper, middle, then the committing lower byte
   task automatic wreg(input logic [1:0] ax, input logic [2:0] r, input logic [23:0] v);
      host.wr_byte(ax, stepper_port_pkg::LANE_CMD, {2'h2, 3'h0, r});
      host.wr_byte(ax, stepper_port_pkg::LANE_UP, v[23:16]);
      host.wr_byte(ax, stepper_port_pkg::LANE_MID, v[15:8]);
      host.wr_byte(ax, stepper_port_pkg::LANE_LOW, v[7:0]);
   endtask

   task automatic rchk(input logic [1:0] ax, input logic [1:0] ln, input logic [7:0] exp);
      logic [7:0] d;
      host.rd_byte(ax, ln, d);
      check("read byte", d, exp);
   endtask

   // ==========================================
   // watchdog: the tests need some 10 us
   initial begin
      #200000;
      fail_count++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge clk);
      #1;
      resetn = 1'b1;
      host.idle(3);
      check("reset cmds", {axis_cfg[0].start_cmd, axis_cfg[0].control_cmd,
         axis_cfg[0].regsel_cmd, axis_cfg[0].outmode_cmd}, 32'h0040_80C0);
      check("oe", data_oe, 1'b0);
      for (int a = 0; a < 4; a++) begin
         wreg(2'(a), 3'h2, {8'(a), 8'h5A, 8'(a + 1)});
      end
      for (int a = 0; a < 4; a++) begin
         check("run speed", axis_cfg[a].regs[2], {8'(a), 8'h5A, 8'(a + 1)});
      end
      host.wr_byte(2'h3, stepper_port_pkg::LANE_CMD, 8'h81);
      host.wr_byte(2'h3, stepper_port_pkg::LANE_UP, 8'h00);
      host.wr_byte(2'h3, stepper_port_pkg::LANE_MID, 8'h0F);
      check("staged", axis_cfg[3].regs[1], 24'h0);
      host.wr_byte(2'h3, stepper_port_pkg::LANE_LOW, 8'h10);
      check("committed", axis_cfg[3].regs[1], 24'h000F10);
      host.wr_byte(2'h3, stepper_port_pkg::LANE_LOW, 8'h11);
      check("stale", axis_cfg[3].regs[1], 24'h000F11);
      check("stop flag", stop_at_start_speed[3], 1'b1);
      wreg(2'h3, 3'h1, 24'h002000);
      check("stop flag", stop_at_start_speed[3], 1'b0);
      wreg(2'h3, 3'h1, 24'h001FFF);
      check("stop flag", stop_at_start_speed[3], 1'b1);
      // ==========================================
      // standard monitor on axis 1
      axis_pins[1] = 8'hA5;
      axis_live[1].operation_status_byte = 8'h3A;
      axis_live[1].remaining = 24'hABCDEF;
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h80);
      axis_live[1].remaining = 24'h123456;
      rchk(2'h1, stepper_port_pkg::LANE_LOW, 8'hEF);
      rchk(2'h1, stepper_port_pkg::LANE_UP, 8'hAB);
      rchk(2'h1, stepper_port_pkg::LANE_MID, 8'hCD);
      rchk(2'h1, stepper_port_pkg::LANE_CMD, 8'h3A);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h80);
      rchk(2'h1, stepper_port_pkg::LANE_MID, 8'h34);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h83);
      rchk(2'h1, stepper_port_pkg::LANE_LOW, 8'hA5);
      rchk(2'h1, stepper_port_pkg::LANE_MID, 8'h00);
      rchk(2'h1, stepper_port_pkg::LANE_UP, 8'h00);
      // ==========================================
      // extended monitor on axis 1
      for (int r = 1; r < 7; r++) begin
         wreg(2'h1, 3'(r), {8'h00, 8'(r), 8'(r + 16)});
      end
      axis_live[1].speed = 16'hBEEF;
      axis_live[1].status_view_slot = 24'h0000C3;
      axis_live[1].output_status_byte = 8'h5C;
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'hE0);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h55);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h06);
      check("start pulses", trig_count, 1);
      for (int r = 1; r < 6; r++) begin
         host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, {2'h2, 3'h0, 3'(r)});
         rchk(2'h1, stepper_port_pkg::LANE_LOW, 8'(r + 16));
         rchk(2'h1, stepper_port_pkg::LANE_MID, 8'(r));
         rchk(2'h1, stepper_port_pkg::LANE_UP, lane3_exp[r]);
      end
      axis_live[1].running = 1'b1;
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h81);
      rchk(2'h1, stepper_port_pkg::LANE_UP, 8'h06);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h86);
      rchk(2'h1, stepper_port_pkg::LANE_LOW, 8'h16);
      rchk(2'h1, stepper_port_pkg::LANE_MID, 8'hEF);
      rchk(2'h1, stepper_port_pkg::LANE_UP, 8'hBE);
      host.wr_byte(2'h1, stepper_port_pkg::LANE_CMD, 8'h87);
      rchk(2'h1, stepper_port_pkg::LANE_LOW, 8'hA5);
      rchk(2'h1, stepper_port_pkg::LANE_MID, 8'h5C);
      rchk(2'h1, stepper_port_pkg::LANE_UP, TYPE_ID);
      conclude();
   end
endmodule
